//--- rtl/pmsq_regs.vh
`ifndef PMSQ_REGS_VH
`define PMSQ_REGS_VH

// ============================================================
// Register offsets (byte addresses)
`define PMSQ_CTRL_OFS      8'h00
`define PMSQ_STATUS_OFS    8'h04
`define PMSQ_FAULT_OFS     8'h08
`define PMSQ_INT_STAT_OFS  8'h0c
`define PMSQ_INT_MASK_OFS  8'h10

// ============================================================
// Control register fields
`define PMSQ_MON_LSB       0
`define PMSQ_MON_MSB       2
`define PMSQ_THR_LSB       3
`define PMSQ_THR_MSB       4
`define PMSQ_POR_LSB       5
`define PMSQ_POR_MSB       6
`define PMSQ_WAKE_LSB      7
`define PMSQ_WAKE_MSB      9
`define PMSQ_PB_EN_BIT     10
`define PMSQ_HIB_BIT       11
`define PMSQ_CTRL_RST      11'h000
`define PMSQ_MON_LAST      3'h6
`define PMSQ_WAKE_NEVER    3'h7

// ============================================================
// Fault and interrupt layouts
`define PMSQ_FAULT_W       6
`define PMSQ_FLT_OT_BIT    4
`define PMSQ_FLT_EXT_BIT   5
`define PMSQ_INT_W         2
`define PMSQ_INT_WARN_BIT  0
`define PMSQ_INT_FLT_BIT   1

// ============================================================
// Timing
`define PMSQ_CLK_NS        8
`define PMSQ_CLK_KHZ       125000
`define PMSQ_STEP_NS       1000
`define PMSQ_POR_US        100
`define PMSQ_WAKE_MS       125

`endif

//--- rtl/pmsq_top.v
`timescale 1ns/10ps
`include "pmsq_regs.vh"
// What this block does
// - Enable three regulators in turn after system good
// - Release core when rails good, interval elapsed
// - Clocks available only after all supplies ready
// - Hibernate command shuts every regulator down
// - Wake timer 125 ms to 8 s, or never
// - Push button event wakes when enabled
// - Wake reruns full start-up, core reinitialized
// - Only fault status survives hibernate
// - Rail drop records fault, resets core
// - Hold reset until rails good, interval expired
// - Over-temperature fault resets core, unmaskable
// - Fault bits survive core reset, stay readable
// - Select one supply monitor source
// - Maskable temperature warning on first interrupt
// - Threshold reference has four levels
module pmsq_top #(
    parameter [31:0] POR_BASE_CYC  = `PMSQ_POR_US * `PMSQ_CLK_KHZ / 1000,
    parameter [31:0] WAKE_BASE_CYC = `PMSQ_WAKE_MS * `PMSQ_CLK_KHZ
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output wire [31:0] rdata,
    input  wire        pg_sys,
    input  wire        pg_io,
    input  wire        pg_mix,
    input  wire        pg_core,
    input  wire        ot_warn,
    input  wire        ot_fault,
    input  wire        push_button_input,
    input  wire        external_reset_low,
    output wire        sys_reg_en,
    output wire [2:0]  reg_en,
    output wire        core_reset_b,
    output wire        clk_avail,
    output wire [2:0]  supply_monitor_signal,
    output wire [1:0]  threshold_reference_level,
    output wire        first_interrupt_line
);

// ============================================================
// States and timing
localparam [4:0] ST_SYSW = 5'h01;
localparam [4:0] ST_SEQ  = 5'h02;
localparam [4:0] ST_POR  = 5'h04;
localparam [4:0] ST_RUN  = 5'h08;
localparam [4:0] ST_HIB  = 5'h10;

localparam [31:0] STEP_CYC =
    (`PMSQ_STEP_NS + `PMSQ_CLK_NS - 1) / `PMSQ_CLK_NS;

reg  [4:0]  state_reg;
reg  [4:0]  state_next;
reg  [31:0] cnt_reg;
reg  [31:0] cnt_next;
reg  [2:0]  ren_reg;
reg  [2:0]  ren_next;
reg         sysen_reg;
reg         sysen_next;
reg         core_rst_b_reg;
reg         clk_av_reg;
reg  [10:0] ctrl_reg;
reg  [10:0] ctrl_next;
reg  [`PMSQ_FAULT_W-1:0] fault_reg;
reg  [`PMSQ_FAULT_W-1:0] fault_set;
reg  [`PMSQ_INT_W-1:0]   int_reg;
reg  [`PMSQ_INT_W-1:0]   mask_reg;
reg  [31:0] rdata_reg;
reg         warn_d_reg;
reg         pb_d_reg;
reg         hib_exit;

wire [3:0]  pg;
wire        all_good;
wire [2:0]  mon_sel;
wire [1:0]  por_sel;
wire [2:0]  wake_sel;
wire        pb_en;
wire [31:0] por_cyc;
wire [31:0] wake_cyc;
wire        wr_ctrl;
wire        wr_fault;
wire        wr_int;
wire        wr_mask;
wire        hib_cmd;
wire        pb_rise;
wire        warn_rise;
wire        hold_rst;
wire [`PMSQ_INT_W-1:0] int_evt;
reg  [31:0] rd_word;
genvar      gi;

// ============================================================
// Decode and field views
assign pg        = {pg_core, pg_mix, pg_io, pg_sys};
assign all_good  = &pg;
assign mon_sel   = ctrl_reg[`PMSQ_MON_MSB:`PMSQ_MON_LSB];
assign por_sel   = ctrl_reg[`PMSQ_POR_MSB:`PMSQ_POR_LSB];
assign wake_sel  = ctrl_reg[`PMSQ_WAKE_MSB:`PMSQ_WAKE_LSB];
assign pb_en     = ctrl_reg[`PMSQ_PB_EN_BIT];
// Interval doubles per select step, so one base count covers the range
assign por_cyc   = POR_BASE_CYC << por_sel;
assign wake_cyc  = WAKE_BASE_CYC << wake_sel;
assign wr_ctrl   = wr && (addr == `PMSQ_CTRL_OFS);
assign wr_fault  = wr && (addr == `PMSQ_FAULT_OFS);
assign wr_int    = wr && (addr == `PMSQ_INT_STAT_OFS);
assign wr_mask   = wr && (addr == `PMSQ_INT_MASK_OFS);
assign hib_cmd   = wr_ctrl && wdata[`PMSQ_HIB_BIT];
assign pb_rise   = push_button_input && !pb_d_reg;
assign warn_rise = ot_warn && !warn_d_reg;
assign hold_rst  = !all_good || ot_fault || !external_reset_low;
assign int_evt[`PMSQ_INT_WARN_BIT] = warn_rise;
assign int_evt[`PMSQ_INT_FLT_BIT]  = |fault_set;

// ============================================================
// Power sequencer
always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    ren_next   = ren_reg;
    sysen_next = sysen_reg;
    fault_set  = {`PMSQ_FAULT_W{1'b0}};
    hib_exit   = 1'b0;
    case (state_reg)
        ST_SYSW: begin
            sysen_next = 1'b1;
            if (pg_sys) begin
                state_next = ST_SEQ;
                ren_next   = 3'h1;
                cnt_next   = STEP_CYC;
            end
        end
        ST_SEQ: begin
            if (cnt_reg != 32'h0) begin
                cnt_next = cnt_reg - 32'h1;
            end else if (ren_reg[2]) begin
                state_next = ST_POR;
                cnt_next   = por_cyc;
            end else begin
                // One more regulator per step, never two at once
                ren_next = {ren_reg[1:0], 1'b1};
                cnt_next = STEP_CYC;
            end
        end
        ST_POR: begin
            // Any bad rail restarts the full interval
            if (hold_rst) begin
                cnt_next = por_cyc;
            end else if (cnt_reg == 32'h0) begin
                state_next = ST_RUN;
            end else begin
                cnt_next = cnt_reg - 32'h1;
            end
        end
        ST_RUN: begin
            fault_set = {~external_reset_low, ot_fault, ~pg};
            if (|fault_set) begin
                state_next = ST_POR;
                cnt_next   = por_cyc;
            end else if (hib_cmd) begin
                state_next = ST_HIB;
                ren_next   = 3'h0;
                sysen_next = 1'b0;
                cnt_next   = wake_cyc;
            end
        end
        ST_HIB: begin
            if ((pb_en && pb_rise) ||
                (wake_sel != `PMSQ_WAKE_NEVER && cnt_reg == 32'h0)) begin
                state_next = ST_SYSW;
                hib_exit   = 1'b1;
            end else if (cnt_reg != 32'h0) begin
                cnt_next = cnt_reg - 32'h1;
            end
        end
        default: begin
            state_next = ST_SYSW;
            ren_next   = 3'h0;
            sysen_next = 1'b0;
        end
    endcase
end

// ============================================================
// Software visible state
always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
        ctrl_next = wdata[10:0];
        // Source 7 has no analog input behind it, keep the old one
        if (wdata[`PMSQ_MON_MSB:`PMSQ_MON_LSB] > `PMSQ_MON_LAST) begin
            ctrl_next[`PMSQ_MON_MSB:`PMSQ_MON_LSB] = mon_sel;
        end
    end
    // Hibernate is only left through a fresh start: volatile state drops
    if (hib_exit) begin
        ctrl_next = `PMSQ_CTRL_RST;
    end
end

// ============================================================
// Interrupt status and mask, one slice per source
generate
    for (gi = 0; gi < `PMSQ_INT_W; gi = gi + 1) begin : g_int
        always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                int_reg[gi]  <= 1'b0;
                mask_reg[gi] <= 1'b0;
            end else begin
                if (hib_exit) begin
                    mask_reg[gi] <= 1'b0;
                end else if (wr_mask) begin
                    mask_reg[gi] <= wdata[gi];
                end
                // Event wins over a clear in the same cycle, so none is lost
                if (int_evt[gi]) begin
                    int_reg[gi] <= 1'b1;
                end else if (hib_exit) begin
                    int_reg[gi] <= 1'b0;
                end else if (wr_int && wdata[gi]) begin
                    int_reg[gi] <= 1'b0;
                end
            end
        end
    end
endgenerate

// ============================================================
// Persistent fault bits: only the chip reset clears them besides software
generate
    for (gi = 0; gi < `PMSQ_FAULT_W; gi = gi + 1) begin : g_fault
        always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                fault_reg[gi] <= 1'b0;
            end else if (fault_set[gi]) begin
                fault_reg[gi] <= 1'b1;
            end else if (wr_fault && wdata[gi]) begin
                fault_reg[gi] <= 1'b0;
            end
        end
    end
endgenerate

// ============================================================
// Sequencer flops
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        state_reg      <= ST_SYSW;
        cnt_reg        <= 32'h0;
        ren_reg        <= 3'h0;
        sysen_reg      <= 1'b0;
        core_rst_b_reg <= 1'b0;
        clk_av_reg     <= 1'b0;
    end else begin
        state_reg      <= state_next;
        cnt_reg        <= cnt_next;
        ren_reg        <= ren_next;
        sysen_reg      <= sysen_next;
        core_rst_b_reg <= (state_next == ST_RUN);
        clk_av_reg     <= (state_next == ST_RUN);
    end
end

// ============================================================
// Control register
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        ctrl_reg <= `PMSQ_CTRL_RST;
    end else begin
        ctrl_reg <= ctrl_next;
    end
end

// ============================================================
// Edge detectors, idle low like their pins so reset makes no false edge
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        warn_d_reg <= 1'b0;
        pb_d_reg   <= 1'b0;
    end else begin
        warn_d_reg <= ot_warn;
        pb_d_reg   <= push_button_input;
    end
end

// ============================================================
// Register read port, data one cycle after the strobe
wire [31:0] status_word;

assign status_word = {18'h0,
                      ren_reg,
                      state_reg,
                      ot_fault,
                      ot_warn,
                      pg};

always @* begin
    case (addr)
        `PMSQ_CTRL_OFS: begin
            rd_word = {21'h0, ctrl_reg};
        end
        `PMSQ_STATUS_OFS: begin
            rd_word = status_word;
        end
        `PMSQ_FAULT_OFS: begin
            rd_word = {26'h0, fault_reg};
        end
        `PMSQ_INT_STAT_OFS: begin
            rd_word = {30'h0, int_reg};
        end
        `PMSQ_INT_MASK_OFS: begin
            rd_word = {30'h0, mask_reg};
        end
        default: begin
            rd_word = 32'h0;
        end
    endcase
end

// Idle cycles return zero so a stale word never looks like fresh data
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        rdata_reg <= 32'h0;
    end else if (rd) begin
        rdata_reg <= rd_word;
    end else begin
        rdata_reg <= 32'h0;
    end
end

// ============================================================
// Outputs
assign rdata                     = rdata_reg;
assign sys_reg_en                = sysen_reg;
assign reg_en                    = ren_reg;
assign core_reset_b              = core_rst_b_reg;
assign clk_avail                 = clk_av_reg;
assign supply_monitor_signal     = mon_sel;
assign threshold_reference_level =
    ctrl_reg[`PMSQ_THR_MSB:`PMSQ_THR_LSB];
// Over-temperature reset has no mask path; the warning and fault interrupts are both gated by the mask
assign first_interrupt_line      = |(int_reg & mask_reg);

endmodule

//--- testbench/pmsq_core_model.sv
`timescale 1ns/10ps
// ====================
// Core side: counts fresh starts of the firmware
module pmsq_core_model (
    input  wire       core_reset_b,
    output reg  [7:0] boots
);
initial boots = 8'h00;
always @(posedge core_reset_b) boots <= boots + 8'h01;
endmodule

//--- testbench/pmsq_props.sv
`timescale 1ns/10ps
// ====================
// Port checks
module pmsq_props #(
    parameter [31:0] POR_BASE_CYC = 32'd4
) (
    input wire       clk,
    input wire       rst_b,
    input wire       pg_sys,
    input wire       pg_io,
    input wire       pg_mix,
    input wire       pg_core,
    input wire       ot_fault,
    input wire       external_reset_low,
    input wire       sys_reg_en,
    input wire [2:0] reg_en,
    input wire       core_reset_b,
    input wire       clk_avail,
    input wire [2:0] supply_monitor_signal,
    input wire       first_interrupt_line
);
reg  [31:0] good_cnt;
wire       all_good = pg_sys & pg_io & pg_mix & pg_core;
// Saturates so a long run of good rails never wraps to a small count
always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
        good_cnt <= 32'h0;
    else if (!all_good)
        good_cnt <= 32'h0;
    else if (good_cnt != 32'hffffffff)
        good_cnt <= good_cnt + 32'h1;
end
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
a_clk_follows: assert property (clk_avail == core_reset_b)
    else $error("clock gate differs from core reset");
a_release_rails: assert property ($rose(core_reset_b) |-> reg_en == 3'h7 && sys_reg_en)
    else $error("core released before all regulators on");
a_por_elapsed: assert property ($rose(core_reset_b) |-> good_cnt >= POR_BASE_CYC)
    else $error("core released before reset interval");
a_reg_order: assert property (reg_en inside {3'h0, 3'h1, 3'h3, 3'h7} && (reg_en == 3'h0 || sys_reg_en))
    else $error("regulators enabled out of order");
a_fault_reset: assert property (core_reset_b && (!all_good || ot_fault || !external_reset_low) |=> !core_reset_b)
    else $error("fault did not reset core");
a_hold_reset: assert property (!core_reset_b && !all_good |=> !core_reset_b)
    else $error("core released with a rail low");
a_hib_off: assert property (!sys_reg_en |-> !core_reset_b && reg_en == 3'h0)
    else $error("regulator on while system supply off");
a_mon_legal: assert property (supply_monitor_signal != 3'h7)
    else $error("monitor source code out of range");
c_boot: cover property ($rose(core_reset_b));
c_hib: cover property ($fell(sys_reg_en));
c_irq: cover property ($rose(first_interrupt_line));
endmodule

//--- testbench/test_pmsq_top.sv
`timescale 1ns/10ps
`include "pmsq_regs.vh"
module test_pmsq_top;
reg         clk, rst_b, wr, rd, ot_warn, ot_fault, pb_in, ext_n;
reg         pg_sys, pg_io, pg_mix, pg_core;
reg  [7:0]  addr, b0;
reg  [3:0]  kill;
reg  [2:0]  m;
reg  [31:0] wdata, seed, d, e;
wire [31:0] rdata;
wire [2:0]  reg_en, mon;
wire [1:0]  thr;
wire [7:0]  boots;
wire        sys_reg_en, core_reset_b, clk_avail, irq;
integer     n_mismatch, checked, i, j;
pmsq_top #(.POR_BASE_CYC(32'd4), .WAKE_BASE_CYC(32'd8)) uut (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pg_sys(pg_sys), .pg_io(pg_io), .pg_mix(pg_mix),
    .pg_core(pg_core), .ot_warn(ot_warn), .ot_fault(ot_fault),
    .push_button_input(pb_in), .external_reset_low(ext_n),
    .sys_reg_en(sys_reg_en), .reg_en(reg_en), .core_reset_b(core_reset_b),
    .clk_avail(clk_avail), .supply_monitor_signal(mon),
    .threshold_reference_level(thr), .first_interrupt_line(irq));
pmsq_core_model core (.core_reset_b(core_reset_b), .boots(boots));
initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
end
// Rails come good a cycle after their regulator, unless forced low
always @(posedge clk) begin
    pg_sys <= sys_reg_en & ~kill[0];
    {pg_core, pg_mix, pg_io} <= reg_en & ~kill[3:1];
end
function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        xs = y ^ (y << 5);
    end
endfunction
function [31:0] flt_exp(input integer k);
    begin
        if (k == 0)
            flt_exp = 32'h1 << 2;
        else if (k == 1)
            flt_exp = 32'h1 << `PMSQ_FLT_OT_BIT;
        else
            flt_exp = 32'h1 << `PMSQ_FLT_EXT_BIT;
    end
endfunction
task cyc(input integer n);
    begin
        repeat (n) @(posedge clk);
        #1;
    end
endtask
task wreg(input [7:0] a, input [31:0] v);
    begin
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    end
endtask
task rreg(input [7:0] a);
    begin
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    end
endtask
task chk(input [63:0] nm, input [31:0] x, input [31:0] g);
    begin
        checked = checked + 1;
        if (g !== x) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %0s expected %h seen %h", nm, x, g);
        end
    end
endtask
task wait_boot;
    begin
        i = 0;
        while (core_reset_b !== 1'b1 && i < 3000) begin
            cyc(1);
            i = i + 1;
        end
        chk("boot", 1, core_reset_b);
    end
endtask
task finish_test;
    begin
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
endtask
initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    finish_test;
end
initial begin
    {rst_b, wr, rd, ot_warn, ot_fault, pb_in, kill} = 10'h000;
    {pg_sys, pg_io, pg_mix, pg_core, ext_n} = 5'h01;
    {addr, wdata, e} = 72'h0;
    {n_mismatch, checked} = 64'h0;
    seed = 32'h96ef;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    wait_boot;
    chk("regs", 7, reg_en);
    chk("clks", 1, clk_avail);
    rreg(`PMSQ_STATUS_OFS);
    chk("state", 8, d[10:6]);
    chk("pg", 32'hf, d[3:0]);
    cyc(1);
    chk("rdidle", 0, rdata);
    rreg(8'h14);
    chk("unmapped", 0, d);
    $display("startup done");
    for (j = 0; j < 8; j = j + 1) begin
        seed = xs(seed);
        m = (seed[2:0] == 3'h7) ? 3'h6 : seed[2:0];
        wreg(`PMSQ_CTRL_OFS, {25'h0, seed[6:5], j[1:0], m});
        cyc(2);
        chk("mon", m, mon);
        chk("thr", j[1:0], thr);
    end
    // Reserved monitor code must leave the source alone
    wreg(`PMSQ_CTRL_OFS, 32'h7);
    cyc(2);
    chk("mon", m, mon);
    $display("select done");
    wreg(`PMSQ_INT_MASK_OFS, 32'h1);
    for (j = 0; j < 2; j = j + 1) begin
        @(posedge clk);
        ot_warn <= 1'b1;
        cyc(3);
        chk("irq", 1 - j, irq);
        rreg(`PMSQ_INT_STAT_OFS);
        chk("wstat", 1, d[0]);
        ot_warn <= 1'b0;
        wreg(`PMSQ_INT_STAT_OFS, 32'h3);
        cyc(1);
        chk("irq", 0, irq);
        wreg(`PMSQ_INT_MASK_OFS, 32'h0);
    end
    $display("warning done");
    for (j = 0; j < 3; j = j + 1) begin
        e = flt_exp(j);
        wreg(`PMSQ_FAULT_OFS, 32'h3f);
        @(posedge clk);
        kill <= (j == 0) ? 4'h4 : 4'h0;
        ot_fault <= (j == 1);
        ext_n <= (j != 2);
        cyc(3);
        chk("fltrst", 0, core_reset_b);
        cyc(40);
        chk("hold", 0, core_reset_b);
        @(posedge clk);
        {kill, ot_fault, ext_n} <= 6'h01;
        wait_boot;
        rreg(`PMSQ_FAULT_OFS);
        chk("fault", e, d);
    end
    $display("fault done");
    b0 = boots;
    wreg(`PMSQ_INT_MASK_OFS, 32'h3);
    wreg(`PMSQ_CTRL_OFS, 32'h800);
    cyc(1);
    chk("hib", 0, {sys_reg_en, reg_en});
    cyc(3);
    chk("sleep", 0, sys_reg_en);
    wait_boot;
    chk("boots", b0 + 1, boots);
    rreg(`PMSQ_FAULT_OFS);
    chk("fault", 32'h20, d);
    rreg(`PMSQ_INT_MASK_OFS);
    chk("mask", 0, d);
    wreg(`PMSQ_CTRL_OFS, 32'hf80);
    cyc(60);
    chk("never", 0, sys_reg_en);
    @(posedge clk);
    pb_in <= 1'b1;
    cyc(2);
    pb_in <= 1'b0;
    wait_boot;
    $display("hibernate done");
    finish_test;
end
endmodule
bind pmsq_top pmsq_props #(.POR_BASE_CYC(POR_BASE_CYC)) chk_i (
    .clk(clk), .rst_b(rst_b), .pg_sys(pg_sys), .pg_io(pg_io), .pg_mix(pg_mix),
    .pg_core(pg_core), .ot_fault(ot_fault), .external_reset_low(external_reset_low),
    .sys_reg_en(sys_reg_en), .reg_en(reg_en), .core_reset_b(core_reset_b),
    .clk_avail(clk_avail), .supply_monitor_signal(supply_monitor_signal),
    .first_interrupt_line(first_interrupt_line));
